// File: rtl/dsmp_pkg.sv
package dsmp_pkg;

  // ************************************************************
  // Bus and register map
  // ************************************************************
  localparam int           ADDR_W       = 8;
  localparam int           DATA_W       = 32;
  localparam int           NPORTS       = 2;
  localparam logic [7:0]   OFF_CTRL_A   = 8'h00;
  localparam logic [7:0]   OFF_STAT_A   = 8'h04;
  localparam logic [7:0]   OFF_CTRL_B   = 8'h08;
  localparam logic [7:0]   OFF_STAT_B   = 8'h0C;
  localparam logic [7:0]   OFF_STRAP    = 8'h10;
  localparam logic [7:0]   OFF_INT_STAT = 8'h14;
  localparam logic [7:0]   OFF_INT_MASK = 8'h18;

  // ************************************************************
  // Modem control register fields
  // ************************************************************
  localparam int           CTRL_W       = 6;
  localparam int           CTRL_DTR     = 0;
  localparam int           CTRL_RTS     = 1;
  localparam int           CTRL_OUT1    = 2;
  localparam int           CTRL_OUT2    = 3;
  localparam int           CTRL_LOOP    = 4;
  localparam int           CTRL_IR      = 5;
  localparam logic [5:0]   CTRL_RST     = 6'h00;

  // ************************************************************
  // Modem status register fields, high means the input is active
  // ************************************************************
  localparam int           MS_W         = 4;
  localparam int           MS_CTS       = 0;
  localparam int           MS_DSR       = 1;
  localparam int           MS_RI        = 2;
  localparam int           MS_DCD       = 3;
  localparam logic [3:0]   MS_RST       = 4'h0;
  localparam logic [3:0]   MS_PIN_IDLE  = 4'hF;

  // ************************************************************
  // Straps and interrupts
  // ************************************************************
  localparam int           STRAP_W      = 6;
  localparam logic [5:0]   STRAP_RST    = 6'h00;
  localparam int           STRAP_ONE    = 0;
  localparam int           STRAP_TWO    = 1;
  localparam int           STRAP_THREE  = 2;
  localparam int           STRAP_FOUR   = 3;
  localparam int           STRAP_FIVE   = 4;
  localparam int           STRAP_SIX    = 5;
  localparam int           INT_W        = 8;
  localparam logic [7:0]   INT_RST      = 8'h00;
  localparam logic [7:0]   MASK_RST     = 8'h00;

endpackage

// File: rtl/dsmp_port.sv
module dsmp_port (
  // Clock, reset and enable
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        ce_i,
  input  wire logic                        strap_phase_i,
  // Control from the register file and the transmit core
  input  wire logic [dsmp_pkg::CTRL_W-1:0] ctrl_i,
  input  wire logic                        tx_data_i,
  // Pins from the modem
  input  wire logic                        rx_pin_i,
  input  wire logic [dsmp_pkg::MS_W-1:0]   status_n_i,
  // Results
  output logic                             rx_data_o,
  output logic [dsmp_pkg::MS_W-1:0]        status_o,
  output logic [dsmp_pkg::MS_W-1:0]        event_o,
  // Pins to the modem
  output logic                             tx_o,
  output logic                             tx_oe_o,
  output logic                             rts_n_o,
  output logic                             rts_oe_o,
  output logic                             dtr_n_o,
  output logic                             dtr_oe_o
);

  logic                      rx_meta;
  logic                      rx_sync;
  logic [dsmp_pkg::MS_W-1:0] st_meta;
  logic [dsmp_pkg::MS_W-1:0] st_sync;
  logic [dsmp_pkg::MS_W-1:0] next_status;
  logic                      loop_on;

  assign loop_on = ctrl_i[dsmp_pkg::CTRL_LOOP];

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      st_meta <= dsmp_pkg::MS_PIN_IDLE;
      st_sync <= dsmp_pkg::MS_PIN_IDLE;
    end else if (ce_i) begin
      rx_meta <= rx_pin_i;
      rx_sync <= rx_meta;
      st_meta <= status_n_i;
      st_sync <= st_meta;
    end
  end

  // In loop mode the status bits follow the control outputs, so software
  // can exercise the status path without a modem attached.
  always_comb begin
    if (loop_on) begin
      next_status[dsmp_pkg::MS_CTS] = ctrl_i[dsmp_pkg::CTRL_RTS];
      next_status[dsmp_pkg::MS_DSR] = ctrl_i[dsmp_pkg::CTRL_DTR];
      next_status[dsmp_pkg::MS_RI]  = ctrl_i[dsmp_pkg::CTRL_OUT1];
      next_status[dsmp_pkg::MS_DCD] = ctrl_i[dsmp_pkg::CTRL_OUT2];
    end else begin
      next_status = ~st_sync;
    end
  end

  // ************************************************************
  // Status, change events and receive data
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_o  <= dsmp_pkg::MS_RST;
      event_o   <= dsmp_pkg::MS_RST;
      rx_data_o <= 1'b1;
    end else if (ce_i) begin
      status_o  <= next_status;
      event_o   <= next_status ^ status_o;
      // Ring reports only its trailing edge, when the ring ends.
      event_o[dsmp_pkg::MS_RI] <= status_o[dsmp_pkg::MS_RI] & ~next_status[dsmp_pkg::MS_RI];
      rx_data_o <= loop_on ? tx_data_i : rx_sync;
    end
  end

  // ************************************************************
  // Output pins
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_o     <= 1'b1;
      rts_n_o  <= 1'b1;
      dtr_n_o  <= 1'b1;
      tx_oe_o  <= 1'b0;
      rts_oe_o <= 1'b0;
      dtr_oe_o <= 1'b0;
    end else if (ce_i) begin
      tx_o     <= ctrl_i[dsmp_pkg::CTRL_IR] | tx_data_i;
      rts_n_o  <= ~(ctrl_i[dsmp_pkg::CTRL_RTS] & ~loop_on);
      dtr_n_o  <= ~(ctrl_i[dsmp_pkg::CTRL_DTR] & ~loop_on);
      tx_oe_o  <= ~strap_phase_i;
      rts_oe_o <= ~strap_phase_i;
      dtr_oe_o <= ~strap_phase_i;
    end
  end

endmodule

// File: rtl/dsmp_top.sv
// Contract
// - Each port receives serial bits from the link on its receive pin; in loop mode the code takes them from the port's transmit data instead.
// - After master reset each transmit pin idles at logic one.
// - In infrared mode the wired transmit pin stays at logic one.
// - Request-to-send is active low, asserted by writing one to its control bit.
// - Terminal-ready is active low, asserted by writing one to its control bit.
// - Request-to-send is inactive high after reset and during loop mode.
// - Terminal-ready is inactive high after reset and during loop mode.
// - Software reads the four modem status inputs in the status register.
// - During LPC reset the six shared output pins act as strap inputs.
//
// Local design decisions: the register addresses and the APB register port.
module dsmp_top (
  // Clock, reset and enable
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        ce_i,
  input  wire logic                        lreset_n_i,
  // APB slave
  input  wire logic                        psel_i,
  input  wire logic                        penable_i,
  input  wire logic                        pwrite_i,
  input  wire logic [dsmp_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [dsmp_pkg::DATA_W-1:0] pwdata_i,
  output logic                             pready_o,
  output logic [dsmp_pkg::DATA_W-1:0]      prdata_o,
  output logic                             pslverr_o,
  // Interrupt
  output logic                             irq_o,
  // Serial core side
  input  wire logic                        tx_data_a_i,
  input  wire logic                        tx_data_b_i,
  output logic                             rx_data_a_o,
  output logic                             rx_data_b_o,
  // Port A pins
  input  wire logic                        serial_rx_port_a_i,
  input  wire logic                        serial_tx_port_a_i,
  output logic                             serial_tx_port_a_o,
  output logic                             serial_tx_port_a_oe_o,
  input  wire logic                        request_send_n_port_a_i,
  output logic                             request_send_n_port_a_o,
  output logic                             request_send_n_port_a_oe_o,
  input  wire logic                        terminal_ready_n_port_a_i,
  output logic                             terminal_ready_n_port_a_o,
  output logic                             terminal_ready_n_port_a_oe_o,
  input  wire logic                        set_ready_n_port_a_i,
  input  wire logic                        clear_send_n_port_a_i,
  input  wire logic                        ring_ind_n_port_a_i,
  input  wire logic                        carrier_det_n_port_a_i,
  // Port B pins
  input  wire logic                        serial_rx_port_b_i,
  input  wire logic                        serial_tx_port_b_i,
  output logic                             serial_tx_port_b_o,
  output logic                             serial_tx_port_b_oe_o,
  input  wire logic                        request_send_n_port_b_i,
  output logic                             request_send_n_port_b_o,
  output logic                             request_send_n_port_b_oe_o,
  input  wire logic                        terminal_ready_n_port_b_i,
  output logic                             terminal_ready_n_port_b_o,
  output logic                             terminal_ready_n_port_b_oe_o,
  input  wire logic                        set_ready_n_port_b_i,
  input  wire logic                        clear_send_n_port_b_i,
  input  wire logic                        ring_ind_n_port_b_i,
  input  wire logic                        carrier_det_n_port_b_i
);

  localparam int NP = dsmp_pkg::NPORTS;

  logic                                mreset;
  logic                                strap_phase;
  logic                                access;
  logic                                done;
  logic                                wr_done;
  logic [dsmp_pkg::CTRL_W-1:0]         ctrl        [NP];
  logic [dsmp_pkg::MS_W-1:0]           status      [NP];
  logic [dsmp_pkg::MS_W-1:0]           event_p     [NP];
  logic [dsmp_pkg::MS_W-1:0]           status_n_in [NP];
  logic [NP-1:0]                       tx_data_in;
  logic [NP-1:0]                       rx_pin_in;
  logic [NP-1:0]                       rx_data;
  logic [NP-1:0]                       tx_pin;
  logic [NP-1:0]                       tx_oe;
  logic [NP-1:0]                       rts_pin;
  logic [NP-1:0]                       rts_oe;
  logic [NP-1:0]                       dtr_pin;
  logic [NP-1:0]                       dtr_oe;
  logic [dsmp_pkg::STRAP_W-1:0]        strap;
  logic [dsmp_pkg::STRAP_W-1:0]        strap_pins;
  logic [dsmp_pkg::INT_W-1:0]          int_stat;
  logic [dsmp_pkg::INT_W-1:0]          int_mask;
  logic [dsmp_pkg::INT_W-1:0]          int_set;
  logic [dsmp_pkg::INT_W-1:0]          int_clr;
  logic [dsmp_pkg::INT_W-1:0]          next_int_stat;

  // ************************************************************
  // Decode helpers
  // ************************************************************
  function automatic logic reg_hit(input logic [dsmp_pkg::ADDR_W-1:0] a);
    case (a)
      dsmp_pkg::OFF_CTRL_A,
      dsmp_pkg::OFF_STAT_A,
      dsmp_pkg::OFF_CTRL_B,
      dsmp_pkg::OFF_STAT_B,
      dsmp_pkg::OFF_STRAP,
      dsmp_pkg::OFF_INT_STAT,
      dsmp_pkg::OFF_INT_MASK: reg_hit = 1'b1;
      default:                reg_hit = 1'b0;
    endcase
  endfunction

  function automatic logic [dsmp_pkg::ADDR_W-1:0] ctrl_addr(input int p);
    ctrl_addr = (p == 0) ? dsmp_pkg::OFF_CTRL_A : dsmp_pkg::OFF_CTRL_B;
  endfunction

  // LPC reset doubles as a master reset for the ports and the control and interrupt registers.
  assign mreset      = rst_i | ~lreset_n_i;
  assign strap_phase = ~lreset_n_i;
  assign access      = psel_i & penable_i;
  assign done        = access & pready_o;
  assign wr_done     = done & pwrite_i & reg_hit(paddr_i);

  // ************************************************************
  // Pin gathering
  // ************************************************************
  assign tx_data_in = {tx_data_b_i, tx_data_a_i};
  assign rx_pin_in  = {serial_rx_port_b_i, serial_rx_port_a_i};

  assign status_n_in[0] = {carrier_det_n_port_a_i, ring_ind_n_port_a_i,
                           set_ready_n_port_a_i, clear_send_n_port_a_i};
  assign status_n_in[1] = {carrier_det_n_port_b_i, ring_ind_n_port_b_i,
                           set_ready_n_port_b_i, clear_send_n_port_b_i};

  assign strap_pins[dsmp_pkg::STRAP_ONE]   = terminal_ready_n_port_a_i;
  assign strap_pins[dsmp_pkg::STRAP_TWO]   = request_send_n_port_a_i;
  assign strap_pins[dsmp_pkg::STRAP_THREE] = serial_tx_port_a_i;
  assign strap_pins[dsmp_pkg::STRAP_FOUR]  = terminal_ready_n_port_b_i;
  assign strap_pins[dsmp_pkg::STRAP_FIVE]  = request_send_n_port_b_i;
  assign strap_pins[dsmp_pkg::STRAP_SIX]   = serial_tx_port_b_i;

  // ************************************************************
  // Strap capture
  // ************************************************************
  // Sampling every cycle while the LPC reset is held means the value kept
  // is the one present on the last cycle before release.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap <= dsmp_pkg::STRAP_RST;
    end else if (ce_i && strap_phase) begin
      strap <= strap_pins;
    end
  end

  // ************************************************************
  // Port instances and control registers
  // ************************************************************
  generate
    for (genvar p = 0; p < NP; p++) begin : g_port
      always_ff @(posedge clk_i) begin
        if (mreset) begin
          ctrl[p] <= dsmp_pkg::CTRL_RST;
        end else if (ce_i && wr_done && paddr_i == ctrl_addr(p)) begin
          ctrl[p] <= pwdata_i[dsmp_pkg::CTRL_W-1:0];
        end
      end

      dsmp_port u_port (
        .clk_i         (clk_i),
        .rst_i         (mreset),
        .ce_i          (ce_i),
        .strap_phase_i (strap_phase),
        .ctrl_i        (ctrl[p]),
        .tx_data_i     (tx_data_in[p]),
        .rx_pin_i      (rx_pin_in[p]),
        .status_n_i    (status_n_in[p]),
        .rx_data_o     (rx_data[p]),
        .status_o      (status[p]),
        .event_o       (event_p[p]),
        .tx_o          (tx_pin[p]),
        .tx_oe_o       (tx_oe[p]),
        .rts_n_o       (rts_pin[p]),
        .rts_oe_o      (rts_oe[p]),
        .dtr_n_o       (dtr_pin[p]),
        .dtr_oe_o      (dtr_oe[p])
      );
    end
  endgenerate

  assign rx_data_a_o                  = rx_data[0];
  assign rx_data_b_o                  = rx_data[1];
  assign serial_tx_port_a_o           = tx_pin[0];
  assign serial_tx_port_a_oe_o        = tx_oe[0];
  assign serial_tx_port_b_o           = tx_pin[1];
  assign serial_tx_port_b_oe_o        = tx_oe[1];
  assign request_send_n_port_a_o      = rts_pin[0];
  assign request_send_n_port_a_oe_o   = rts_oe[0];
  assign request_send_n_port_b_o      = rts_pin[1];
  assign request_send_n_port_b_oe_o   = rts_oe[1];
  assign terminal_ready_n_port_a_o    = dtr_pin[0];
  assign terminal_ready_n_port_a_oe_o = dtr_oe[0];
  assign terminal_ready_n_port_b_o    = dtr_pin[1];
  assign terminal_ready_n_port_b_oe_o = dtr_oe[1];

  // ************************************************************
  // Interrupt status and mask
  // ************************************************************
  assign int_set = {event_p[1], event_p[0]};
  assign int_clr = (wr_done && paddr_i == dsmp_pkg::OFF_INT_STAT)
                 ? pwdata_i[dsmp_pkg::INT_W-1:0] : dsmp_pkg::INT_RST;
  // A change landing in the clearing cycle is kept: set beats clear.
  assign next_int_stat = (int_stat & ~int_clr) | int_set;

  always_ff @(posedge clk_i) begin
    if (mreset) begin
      int_stat <= dsmp_pkg::INT_RST;
      irq_o    <= 1'b0;
    end else if (ce_i) begin
      int_stat <= next_int_stat;
      irq_o    <= |(next_int_stat & int_mask);
    end
  end

  always_ff @(posedge clk_i) begin
    if (mreset) begin
      int_mask <= dsmp_pkg::MASK_RST;
    end else if (ce_i && wr_done && paddr_i == dsmp_pkg::OFF_INT_MASK) begin
      int_mask <= pwdata_i[dsmp_pkg::INT_W-1:0];
    end
  end

  // ************************************************************
  // APB handshake and read data
  // ************************************************************
  // One wait state: read data is loaded in the first access cycle so it
  // comes straight from a flop when pready rises.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else if (ce_i) begin
      pready_o  <= access & ~pready_o;
      pslverr_o <= access & ~pready_o & ~reg_hit(paddr_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prdata_o <= '0;
    end else if (ce_i) begin
      prdata_o <= '0;
      if (access && !pready_o && !pwrite_i) begin
        case (paddr_i)
          dsmp_pkg::OFF_CTRL_A:   prdata_o[dsmp_pkg::CTRL_W-1:0]  <= ctrl[0];
          dsmp_pkg::OFF_STAT_A:   prdata_o[dsmp_pkg::MS_W-1:0]    <= status[0];
          dsmp_pkg::OFF_CTRL_B:   prdata_o[dsmp_pkg::CTRL_W-1:0]  <= ctrl[1];
          dsmp_pkg::OFF_STAT_B:   prdata_o[dsmp_pkg::MS_W-1:0]    <= status[1];
          dsmp_pkg::OFF_STRAP:    prdata_o[dsmp_pkg::STRAP_W-1:0] <= strap;
          dsmp_pkg::OFF_INT_STAT: prdata_o[dsmp_pkg::INT_W-1:0]   <= int_stat;
          dsmp_pkg::OFF_INT_MASK: prdata_o[dsmp_pkg::INT_W-1:0]   <= int_mask;
          default:                prdata_o <= '0;
        endcase
      end
    end
  end

endmodule

// File: verification/dsmp_top_assertions.sv
module dsmp_top_assertions (
  // Clock, reset and bus
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        lreset_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic        pready_o,
  input  wire logic        irq_o,
  // Shared pins
  input  wire logic        serial_tx_port_a_o,
  input  wire logic        serial_tx_port_a_oe_o,
  input  wire logic        request_send_n_port_a_o,
  input  wire logic        terminal_ready_n_port_a_o,
  input  wire logic        serial_tx_port_b_o,
  input  wire logic        serial_tx_port_b_oe_o,
  input  wire logic        request_send_n_port_b_o,
  input  wire logic        terminal_ready_n_port_b_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  logic wr_a;
  logic wr_b;
  assign wr_a = psel_i && penable_i && pready_o && pwrite_i && paddr_i == dsmp_pkg::OFF_CTRL_A;
  assign wr_b = psel_i && penable_i && pready_o && pwrite_i && paddr_i == dsmp_pkg::OFF_CTRL_B;
  chk_tx_mark_reset: assert property (disable iff (rst_i)
    $fell(rst_i) |-> serial_tx_port_a_o && serial_tx_port_b_o) else $error("tx not at mark");
  chk_rts_idle_reset: assert property (disable iff (rst_i)
    $fell(rst_i) |-> request_send_n_port_a_o && request_send_n_port_b_o) else $error("rts low");
  chk_dtr_idle_reset: assert property (disable iff (rst_i)
    $fell(rst_i) |-> terminal_ready_n_port_a_o && terminal_ready_n_port_b_o) else $error("dtr low");
  chk_strap_pins_float: assert property (disable iff (rst_i)
    !lreset_n_i |=> !serial_tx_port_a_oe_o && !serial_tx_port_b_oe_o)
    else $error("pin driven during strap phase");
  chk_drive_after_release: assert property (disable iff (rst_i || !lreset_n_i || !ce_i)
    $rose(lreset_n_i) |-> ##[1:3] serial_tx_port_a_oe_o && serial_tx_port_b_oe_o)
    else $error("pins not driven after strap phase");
  chk_ir_forces_mark: assert property (disable iff (rst_i || !lreset_n_i)
    wr_a && pwdata_i[5] |=> ##1 serial_tx_port_a_o [*3]) else $error("tx left mark in ir mode");
  chk_loop_idles_a: assert property (disable iff (rst_i || !lreset_n_i)
    wr_a && pwdata_i[4] |=> ##1 request_send_n_port_a_o && terminal_ready_n_port_a_o)
    else $error("control pins active in loop mode");
  chk_ctrl_drives_a: assert property (disable iff (rst_i || !lreset_n_i)
    wr_a && !pwdata_i[4] |=> ##1 request_send_n_port_a_o == !$past(pwdata_i[1], 2)
    && terminal_ready_n_port_a_o == !$past(pwdata_i[0], 2)) else $error("port a pins wrong");
  chk_ctrl_drives_b: assert property (disable iff (rst_i || !lreset_n_i)
    wr_b && !pwdata_i[4] |=> ##1 request_send_n_port_b_o == !$past(pwdata_i[1], 2)
    && terminal_ready_n_port_b_o == !$past(pwdata_i[0], 2)) else $error("port b pins wrong");
  cov_loop_a: cover property (wr_a && pwdata_i[4]);
  cov_write_b: cover property (wr_b);
  cov_irq: cover property ($rose(irq_o));
endmodule

bind dsmp_top dsmp_top_assertions dsmp_top_assertions_inst (.clk_i(clk_i), .rst_i(rst_i),
  .ce_i(ce_i), .lreset_n_i(lreset_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
  .irq_o(irq_o), .serial_tx_port_a_o(serial_tx_port_a_o),
  .serial_tx_port_a_oe_o(serial_tx_port_a_oe_o), .request_send_n_port_a_o(request_send_n_port_a_o),
  .terminal_ready_n_port_a_o(terminal_ready_n_port_a_o), .serial_tx_port_b_o(serial_tx_port_b_o),
  .serial_tx_port_b_oe_o(serial_tx_port_b_oe_o), .request_send_n_port_b_o(request_send_n_port_b_o),
  .terminal_ready_n_port_b_o(terminal_ready_n_port_b_o));

// File: verification/dsmp_modem.sv
module dsmp_modem (
  // Bench commands, status bits high means active
  input  wire logic [3:0] sts_a_i,
  input  wire logic [3:0] sts_b_i,
  input  wire logic       echo_i,
  input  wire logic [5:0] strap_i,
  // Shared pins in strap register bit order
  input  wire logic [5:0] drv_i,
  input  wire logic [5:0] oe_i,
  output logic      [5:0] lvl_o,
  // Modem status and receive lines
  output logic      [3:0] sts_n_a_o,
  output logic      [3:0] sts_n_b_o,
  output logic            rx_a_o,
  output logic            rx_b_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // A released pin settles to its board strap resistor, never to the last driven value.
  assign lvl_o = (oe_i & drv_i) | (~oe_i & strap_i);
  assign sts_n_a_o = ~sts_a_i;
  assign sts_n_b_o = ~sts_b_i;
  // With echo off the line idles at mark, as an idle modem leaves it.
  assign rx_a_o = echo_i ? lvl_o[2] : 1'b1;
  assign rx_b_o = echo_i ? lvl_o[5] : 1'b1;
endmodule

// File: verification/tb_dual_serial_modem_pins.sv
module tb_dual_serial_modem_pins;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_i, lreset_n, psel, penable, pwrite, txa, txb, echo;
  logic        pready, pslverr, irq, rxa, rxb, ra, rb;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [5:0]  strap, drv, oe, lvl;
  logic [3:0]  sts_a, sts_b, sn_a, sn_b;
  int          n_fail = 0;
  int          checked = 0;
  always #4 clk_i = ~clk_i;
  dsmp_modem dsmp_modem_inst (.sts_a_i(sts_a), .sts_b_i(sts_b), .echo_i(echo), .strap_i(strap),
    .drv_i(drv), .oe_i(oe), .lvl_o(lvl), .sts_n_a_o(sn_a), .sts_n_b_o(sn_b), .rx_a_o(ra),
    .rx_b_o(rb));
  dsmp_top dsmp_top_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .lreset_n_i(lreset_n),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr), .irq_o(irq), .tx_data_a_i(txa),
    .tx_data_b_i(txb), .rx_data_a_o(rxa), .rx_data_b_o(rxb), .serial_rx_port_a_i(ra),
    .serial_tx_port_a_i(lvl[2]), .serial_tx_port_a_o(drv[2]), .serial_tx_port_a_oe_o(oe[2]),
    .request_send_n_port_a_i(lvl[1]), .request_send_n_port_a_o(drv[1]),
    .request_send_n_port_a_oe_o(oe[1]), .terminal_ready_n_port_a_i(lvl[0]),
    .terminal_ready_n_port_a_o(drv[0]), .terminal_ready_n_port_a_oe_o(oe[0]),
    .set_ready_n_port_a_i(sn_a[1]), .clear_send_n_port_a_i(sn_a[0]),
    .ring_ind_n_port_a_i(sn_a[2]), .carrier_det_n_port_a_i(sn_a[3]), .serial_rx_port_b_i(rb),
    .serial_tx_port_b_i(lvl[5]), .serial_tx_port_b_o(drv[5]), .serial_tx_port_b_oe_o(oe[5]),
    .request_send_n_port_b_i(lvl[4]), .request_send_n_port_b_o(drv[4]),
    .request_send_n_port_b_oe_o(oe[4]), .terminal_ready_n_port_b_i(lvl[3]),
    .terminal_ready_n_port_b_o(drv[3]), .terminal_ready_n_port_b_oe_o(oe[3]),
    .set_ready_n_port_b_i(sn_b[1]), .clear_send_n_port_b_i(sn_b[0]),
    .ring_ind_n_port_b_i(sn_b[2]), .carrier_det_n_port_b_i(sn_b[3]));
  // ************************************************************
  // Bus cycles and comparison
  // ************************************************************
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    cmp(r, x);
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_straps();
    repeat (4) @(posedge clk_i);
    lreset_n <= 1'b1;
    strap <= 6'h12;
    repeat (4) @(posedge clk_i);
    cmp(32'(oe), 32'h3F);
    cmp(32'(lvl), 32'h3F);
    rd(dsmp_pkg::OFF_STRAP, 32'h2D);
    $display("straps done");
  endtask
  task automatic t_ctrl();
    wr(dsmp_pkg::OFF_CTRL_A, 32'h03);
    wr(dsmp_pkg::OFF_CTRL_B, 32'h01);
    repeat (2) @(posedge clk_i);
    cmp(32'(lvl), 32'h34);
    wr(dsmp_pkg::OFF_CTRL_A, 32'h13);
    repeat (2) @(posedge clk_i);
    cmp(32'(lvl), 32'h37);
    rd(dsmp_pkg::OFF_STAT_A, 32'h3);
    txa <= 1'b0;
    wr(dsmp_pkg::OFF_CTRL_A, 32'h20);
    repeat (2) @(posedge clk_i);
    cmp(32'(lvl[2]), 32'h1);
    wr(dsmp_pkg::OFF_CTRL_A, 32'h00);
    repeat (2) @(posedge clk_i);
    cmp(32'(lvl), 32'h33);
    txa <= 1'b1;
    wr(dsmp_pkg::OFF_CTRL_B, 32'h00);
    $display("control pins done");
  endtask
  task automatic t_status();
    wr(dsmp_pkg::OFF_INT_MASK, 32'hFF);
    for (int i = 0; i < 4; i++) begin
      sts_a <= 4'h1 << i;
      repeat (6) @(posedge clk_i);
      rd(dsmp_pkg::OFF_STAT_A, 32'h1 << i);
      rd(dsmp_pkg::OFF_STAT_B, 32'h0);
    end
    sts_a <= 4'h0;
    repeat (6) @(posedge clk_i);
    wr(dsmp_pkg::OFF_INT_STAT, 32'hFF);
    wr(dsmp_pkg::OFF_INT_MASK, 32'h00);
    cmp(32'(irq), 32'h0);
    sts_b <= 4'h8;
    repeat (6) @(posedge clk_i);
    cmp(32'(irq), 32'h0);
    rd(dsmp_pkg::OFF_INT_STAT, 32'h80);
    wr(dsmp_pkg::OFF_INT_MASK, 32'h80);
    repeat (2) @(posedge clk_i);
    cmp(32'(irq), 32'h1);
    wr(dsmp_pkg::OFF_INT_STAT, 32'h80);
    repeat (2) @(posedge clk_i);
    cmp(32'(irq), 32'h0);
    sts_b <= 4'h0;
    $display("status and interrupt done");
  endtask
  task automatic t_echo_and_refusals();
    logic [31:0] r;
    logic        e;
    echo <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      txa <= i[0];
      txb <= ~i[0];
      repeat (8) @(posedge clk_i);
      cmp(32'({rxa, rxb}), 32'({i[0], ~i[0]}));
    end
    echo <= 1'b0;
    txa <= 1'b1;
    txb <= 1'b1;
    apb(1'b0, 8'h40, 32'h0, r, e);
    cmp({r[30:0], e}, 32'h1);
    wr(dsmp_pkg::OFF_STAT_A, 32'hF);
    rd(dsmp_pkg::OFF_STAT_A, 32'h0);
    $display("echo and refusals done");
  endtask
  initial begin
    rst_i = 1'b1;
    lreset_n = 1'b0;
    {psel, penable, pwrite, echo} = 4'h0;
    {txa, txb} = 2'h3;
    paddr = 8'h00;
    pwdata = 32'h0;
    strap = 6'h2D;
    {sts_a, sts_b} = 8'h00;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_straps();
    t_ctrl();
    t_status();
    t_echo_and_refusals();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    $display("ERROR %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule
